// >>> logic/dbr_pkg.sv
// Package: timing constants, output carrier and states for the dual-button reset timer
package dbr_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SETUP_S = 10;        // Build options: 6, 8, 10, 12 s
  localparam int unsigned RESET_MS = 500;      // Build options: 500, 1000, 2000 ms
  localparam int unsigned DEGLITCH_US = 1500;  // Typical deglitch interval, 1.5 ms
  localparam int unsigned TICK_HZ = 1000;      // Time base tick of 1 ms for long counts
  localparam int unsigned TICK_CYC = CLK_HZ / TICK_HZ;
  localparam int unsigned SETUP_TICKS = SETUP_S * TICK_HZ;
  localparam int unsigned RESET_TICKS = RESET_MS * TICK_HZ / 1000;
  localparam int unsigned DEGLITCH_CYC = DEGLITCH_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    DBR_ARMED = 2'b00,
    DBR_PULSE = 2'b01,
    DBR_HOLD  = 2'b10
  } dbr_state_t;

  typedef struct packed {
    logic rst_oe;
    logic and_oe;
  } dbr_drive_t;

endpackage : dbr_pkg

// >>> logic/dbr_deglitch.sv
// Deglitch filter: level follows input only after it is stable for a full interval
`timescale 1ns/1ps
module dbr_deglitch import dbr_pkg::*; #(
  parameter int unsigned STABLE_CYC = DEGLITCH_CYC,
  parameter int unsigned CW = 24
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_level,
  output logic o_level
);

  logic [CW-1:0] cnt_q;
  logic level_q;

  // ----------------------------------------
  // Stability counter
  // ----------------------------------------
  // Any change shorter than STABLE_CYC restarts the count and is dropped
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else if (i_level == level_q) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      level_q <= 1'b1;
    end else if (i_level != level_q && cnt_q == CW'(STABLE_CYC - 1)) begin
      level_q <= i_level;
    end
  end

  assign o_level = level_q;

  a_glitch_ignored: assert property (@(posedge i_clk) disable iff (i_rst)
    (level_q != $past(level_q)) |-> ($past(cnt_q) == CW'(STABLE_CYC - 1)))
    else $error("Filtered level changed before full stable interval");

endmodule : dbr_deglitch

// >>> logic/dbr_timer.sv
// Top: dual push-button reset timer with deglitched AND output
// ----------------------------------------
// Overview of operation
// - Both low past setup period asserts reset
// - One reset pulse of timeout width
// - Input release during setup clears timer
// - New pulse needs full fresh setup period
// - AND output low after deglitch interval
// - AND output low while both stay low
// - AND releases after deglitched high input
// - Continued hold gives no further pulses
// - Release during pulse does not shorten it
// - Rearm after both high past deglitch
// - Short assertions or releases are ignored, except a release during setup restarts it
// - Input order makes no difference
// - Outputs only pull low, never drive high
// ----------------------------------------
`timescale 1ns/1ps
module dbr_timer import dbr_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter int unsigned SETUP_TICK_CNT = SETUP_TICKS,
  parameter int unsigned RESET_TICK_CNT = RESET_TICKS,
  parameter int unsigned DEGLITCH_CYCLES = DEGLITCH_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_manual_reset_in_a_n,
  input wire logic i_manual_reset_in_b_n,
  output logic o_reset_n_out,
  output logic o_reset_n_oe,
  output logic o_debounced_and_output_out,
  output logic o_debounced_and_output_oe
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam int TW = 17;
  localparam int PW = 24;
  logic [PW-1:0] pre_q;
  logic tick;
  logic both_low_raw;
  logic both_high_raw;
  logic and_flt_n;
  logic high_flt;
  logic [TW-1:0] setup_q;
  logic [TW-1:0] pulse_q;
  dbr_state_t state_q;
  dbr_drive_t drv;

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  // Long intervals run on a 1 ms tick, keeping the counters narrow
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_q <= '0;
    end else if (pre_q == PW'(TICK_CYCLES - 1)) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end
  assign tick = (pre_q == PW'(TICK_CYCLES - 1));

  // Symmetric combining, so the order of presses is irrelevant
  assign both_low_raw = ~i_manual_reset_in_a_n & ~i_manual_reset_in_b_n;
  assign both_high_raw = i_manual_reset_in_a_n & i_manual_reset_in_b_n;

  // ----------------------------------------
  // Deglitch filters
  // ----------------------------------------
  // AND path: low once both low for the interval, high once either high for it
  dbr_deglitch #(.STABLE_CYC(DEGLITCH_CYCLES), .CW(PW)) u_and_flt (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_level(~both_low_raw),
    .o_level(and_flt_n)
  );

  // Rearm path: both high for the interval
  dbr_deglitch #(.STABLE_CYC(DEGLITCH_CYCLES), .CW(PW)) u_rearm_flt (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_level(both_high_raw),
    .o_level(high_flt)
  );

  // ----------------------------------------
  // Setup timer
  // ----------------------------------------
  // Counts on raw inputs; a glitch high during setup restarts the count
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      setup_q <= '0;
    end else if (state_q != DBR_ARMED || !both_low_raw) begin
      setup_q <= '0;
    end else if (tick) begin
      setup_q <= setup_q + 1'b1;
    end
  end

  // ----------------------------------------
  // Pulse timer
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pulse_q <= '0;
    end else if (state_q != DBR_PULSE) begin
      pulse_q <= '0;
    end else if (tick) begin
      pulse_q <= pulse_q + 1'b1;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= DBR_ARMED;
    end else begin
      case (state_q)
        DBR_ARMED: begin
          if (both_low_raw && tick && setup_q == TW'(SETUP_TICK_CNT - 1)) begin
            state_q <= DBR_PULSE;
          end
        end
        DBR_PULSE: begin
          // Inputs are ignored here, the pulse always runs full width
          if (tick && pulse_q == TW'(RESET_TICK_CNT - 1)) begin
            state_q <= DBR_HOLD;
          end
        end
        DBR_HOLD: begin
          // Stays here while held low, so no repeat pulses
          if (high_flt) begin
            state_q <= DBR_ARMED;
          end
        end
        default: begin
          state_q <= DBR_ARMED;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Open-drain outputs
  // ----------------------------------------
  // One assignment fills the carrier, so it has a single driver
  assign drv = '{rst_oe: (state_q == DBR_PULSE), and_oe: ~and_flt_n};
  assign o_reset_n_out = 1'b0;
  assign o_debounced_and_output_out = 1'b0;
  assign o_reset_n_oe = drv.rst_oe;
  assign o_debounced_and_output_oe = drv.and_oe;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_pulse_start: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_reset_n_oe) |-> $past(both_low_raw) && $past(setup_q) == TW'(SETUP_TICK_CNT - 1))
    else $error("Reset pulse began without a full setup period");

  a_pulse_width: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_reset_n_oe) |-> $past(pulse_q) == TW'(RESET_TICK_CNT - 1) && $past(tick))
    else $error("Reset pulse ended early or late");

  a_setup_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    !both_low_raw |=> setup_q == '0)
    else $error("Setup timer not cleared on input release");

  a_no_repeat: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_reset_n_oe) |-> state_q == DBR_HOLD)
    else $error("Sequencer did not wait for rearm after pulse");

  a_pulse_holds: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_reset_n_oe && !(tick && pulse_q == TW'(RESET_TICK_CNT - 1))) |=> o_reset_n_oe)
    else $error("Reset pulse cut short");

  a_rearm_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    ($past(state_q) == DBR_HOLD && state_q == DBR_ARMED) |-> $past(high_flt))
    else $error("Rearmed without deglitched release");

  a_and_follows: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_debounced_and_output_oe && both_low_raw) |=> o_debounced_and_output_oe)
    else $error("AND output released while both inputs low");

  a_never_high: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_reset_n_out && !o_debounced_and_output_out)
    else $error("Open-drain output driven high");

  // ----------------------------------------
  // Check helpers
  // ----------------------------------------
  // Run lengths of the raw condition; they saturate so long holds never wrap
  logic [PW-1:0] low_run_q;
  logic [PW-1:0] rel_run_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      low_run_q <= '0;
    end else if (!both_low_raw) begin
      low_run_q <= '0;
    end else if (low_run_q != '1) begin
      low_run_q <= low_run_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rel_run_q <= '0;
    end else if (both_low_raw) begin
      rel_run_q <= '0;
    end else if (rel_run_q != '1) begin
      rel_run_q <= rel_run_q + 1'b1;
    end
  end

  a_setup_step: assert property (@(posedge i_clk) disable iff (i_rst)
    (setup_q != '0) |-> $past(both_low_raw) && $past(state_q) == DBR_ARMED &&
      (setup_q == $past(setup_q) || (setup_q == $past(setup_q) + TW'(1) && $past(tick))))
    else $error("Setup timer moved without a continuous both-low hold");

  a_and_assert: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_debounced_and_output_oe) |-> low_run_q >= PW'(DEGLITCH_CYCLES))
    else $error("AND output asserted before a full deglitch interval");

  a_and_release: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_debounced_and_output_oe) |-> rel_run_q >= PW'(DEGLITCH_CYCLES))
    else $error("AND output released before a full deglitch interval");

  a_pulse_on_tick: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_reset_n_oe) |-> $past(tick))
    else $error("Reset pulse began off the time base tick");

endmodule : dbr_timer

// >>> dv/dbr_partner.sv
// Partner model: buttons, pulled-up output lines, reset pulse monitor
`timescale 1ns/1ps
module dbr_partner (
  input wire logic i_clk,
  input wire logic i_press_a,
  input wire logic i_press_b,
  input wire logic i_rst_out,
  input wire logic i_rst_oe,
  input wire logic i_and_out,
  input wire logic i_and_oe,
  output logic o_btn_a_n,
  output logic o_btn_b_n,
  output logic o_rst_line_n,
  output logic o_and_line_n,
  output logic [15:0] o_pulses,
  output logic [15:0] o_width,
  output logic [15:0] o_setup_seen
);
  logic [15:0] low_q = 16'h0;
  logic [15:0] run_q = 16'h0;
  logic [15:0] pulses_q = 16'h0;
  logic [15:0] width_q = 16'h0;
  logic [15:0] seen_q = 16'h0;
  // Released buttons rise through their pull-ups
  assign o_btn_a_n = ~i_press_a;
  assign o_btn_b_n = ~i_press_b;
  // A driven high looks the same as the pull-up on the line, so open drain is checked on the data pins
  assign o_rst_line_n = i_rst_oe ? i_rst_out : 1'b1;
  assign o_and_line_n = i_and_oe ? i_and_out : 1'b1;
  assign o_pulses = pulses_q;
  assign o_width = width_q;
  assign o_setup_seen = seen_q;
  always @(posedge i_clk) begin
    low_q <= (o_btn_a_n | o_btn_b_n) ? 16'h0 : low_q + 16'h1;
    run_q <= (o_rst_line_n !== 1'b0) ? 16'h0 : run_q + 16'h1;
    if (o_rst_line_n === 1'b0 && run_q == 16'h0) begin
      pulses_q <= pulses_q + 16'h1;
      seen_q <= low_q;
    end
    if (o_rst_line_n === 1'b1 && run_q != 16'h0) width_q <= run_q;
  end
endmodule : dbr_partner

// >>> dv/dbr_timer_tb_top.sv
// Testbench: button scenarios against the reset timer
`timescale 1ns/1ps
module dbr_timer_tb_top;
  localparam int TK = 10;
  localparam int ST = 20;
  localparam int RT = 5;
  localparam int DG = 8;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic pa = 1'b0;
  logic pb = 1'b0;
  logic ba_n, bb_n, ro, roe, ao, aoe, rl_n, al_n;
  logic [15:0] pulses, width, seen;
  int err_count = 0;
  int checks_done = 0;
  dbr_timer #(.TICK_CYCLES(TK), .SETUP_TICK_CNT(ST), .RESET_TICK_CNT(RT),
    .DEGLITCH_CYCLES(DG)) dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_manual_reset_in_a_n(ba_n), .i_manual_reset_in_b_n(bb_n), .o_reset_n_out(ro),
    .o_reset_n_oe(roe), .o_debounced_and_output_out(ao), .o_debounced_and_output_oe(aoe));
  dbr_partner pm (.i_clk(i_clk), .i_press_a(pa), .i_press_b(pb), .i_rst_out(ro),
    .i_rst_oe(roe), .i_and_out(ao), .i_and_oe(aoe), .o_btn_a_n(ba_n), .o_btn_b_n(bb_n),
    .o_rst_line_n(rl_n), .o_and_line_n(al_n), .o_pulses(pulses), .o_width(width),
    .o_setup_seen(seen));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_rng(string nm, logic [15:0] lo, logic [15:0] hi, logic [15:0] g);
    checks_done++;
    if ($isunknown(g) || g < lo || g > hi) begin
      err_count++;
      $display("CHECK FAILED %s expected %h..%h seen %h", nm, lo, hi, g);
    end
  endtask : chk_rng
  // Presses buttons (1 = pressed) and waits n edges; results are read 1 ns after the last
  task automatic drive(logic a, logic b, int n);
    @(posedge i_clk);
    pa <= a;
    pb <= b;
    repeat (n) @(posedge i_clk);
    #1;
  endtask : drive
  task automatic t_and_path;
    drive(1, 1, DG - 4);
    chk("and_glitch", 16'h1, al_n);
    drive(0, 0, DG + 2);
    drive(1, 1, DG - 2);
    chk("and_early", 16'h1, al_n);
    drive(1, 1, 6);
    chk("and_low", 16'h0, al_n);
    drive(0, 1, DG - 4);
    chk("and_hold", 16'h0, al_n);
    drive(1, 1, 2);
    drive(1, 0, DG + 4);
    chk("and_release", 16'h1, al_n);
    chk("no_pulse", 16'h0, pulses);
    $display("test and_path done");
  endtask : t_and_path
  task automatic t_setup_pulse;
    drive(1, 1, 150);
    drive(1, 0, 2);
    drive(1, 1, 150);
    chk("restart", 16'h0, pulses);
    drive(1, 1, 110);
    chk("one_pulse", 16'h1, pulses);
    chk("width", 16'(RT * TK), width);
    chk_rng("setup", 16'((ST - 1) * TK + 1), 16'(ST * TK), seen);
    drive(1, 1, 300);
    chk("long_hold", 16'h1, pulses);
    drive(0, 0, DG - 4);
    drive(1, 1, 260);
    chk("no_rearm", 16'h1, pulses);
    drive(0, 0, DG + 4);
    drive(1, 1, 260);
    chk("rearm", 16'h2, pulses);
    drive(0, 0, DG + 4);
    $display("test setup_pulse done");
  endtask : t_setup_pulse
  task automatic t_order_release;
    int i;
    drive(0, 1, 3);
    drive(1, 1, 0);
    for (i = 0; i < 260 && rl_n !== 1'b0; i++) drive(1, 1, 0);
    drive(0, 0, 70);
    chk("b_first", 16'h3, pulses);
    chk("full_width", 16'(RT * TK), width);
    chk("and_idle", 16'h1, al_n);
    chk("rst_data", 16'h0, {15'h0, ro});
    chk("and_data", 16'h0, {15'h0, ao});
    $display("test order_release done");
  endtask : t_order_release
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    chk("rst_idle", 16'h1, rl_n);
    t_and_path();
    t_setup_pulse();
    t_order_release();
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    err_count++;
    print_verdict();
  end
endmodule : dbr_timer_tb_top
